/* File: include/pfa_pkg.sv */
// Package with register map, field layout and constants of the PLL and auxiliary clock config
package pfa_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] PFA_OFS_PLL_MULT_DIV = 12'h000;
  localparam logic [11:0] PFA_OFS_AUX_CLK_CTRL = 12'h004;
  localparam logic [11:0] PFA_OFS_AUX_STATUS = 12'h008;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int PFA_FBD_MSB = 8;
  localparam int PFA_SRC_SEL_BIT = 13;
  localparam int PFA_MODE_MSB = 12;
  localparam int PFA_MODE_LSB = 11;
  localparam int PFA_POST_MSB = 10;
  localparam int PFA_POST_LSB = 8;
  localparam int PFA_REF_SEL_BIT = 7;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [8:0] PFA_FBD_RESET = 9'h030;
  localparam logic [15:0] PFA_FBD_MASK = 16'h01FF;
  localparam logic [15:0] PFA_ACC_MASK = 16'h3F80;
  localparam logic [15:0] PFA_ACC_RESET = 16'h0000;
  localparam logic [9:0] PFA_MULT_OFFSET = 10'h002;

  // ----------------------------------------
  // Bus response codes
  // ----------------------------------------
  localparam logic [1:0] PFA_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFA_RESP_SLVERR = 2'h2;

  // Oscillator mode
  typedef enum logic [1:0] {
    PFA_OSC_OFF = 2'h0,
    PFA_OSC_HIGH_SPEED_CRYSTAL = 2'h1,
    PFA_OSC_MEDIUM_SPEED_CRYSTAL = 2'h2,
    PFA_OSC_EXTERNAL_CLOCK = 2'h3
  } pfa_osc_mode_t;

  // Decoded auxiliary clock configuration
  typedef struct packed {
    logic divider_from_aux;
    logic ref_is_primary;
    logic [3:0] osc_enables;
    logic [8:0] postdiv_ratio;
  } pfa_aux_cfg_t;
endpackage

/* File: verilog/pfa_clock_cfg.sv */
// PLL feedback divisor and auxiliary clock generator configuration with AXI4-Lite slave
// Summary of operation
// - At power-on the feedback divisor field holds 000110000, a multiplier of 50.
// - Both registers return to defaults only on power-on reset, not on other resets.
// - Source-select bit 13 feeds the aux divider from the aux oscillator when 1, else PLL.
// - Mode bits 12-11 pick external clock, medium crystal, high crystal or oscillator off.
// - Bits 10-8 set the aux post-divider ratio from 1 up to 256, with 256 after reset.
// - Unimplemented bits of both registers read as zero.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
module pfa_clock_cfg
  import pfa_pkg::*;
(
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock generator controls
  output logic [9:0] pll_multiplier,
  output logic aux_divider_source_select,
  output logic aux_reference_source_select,
  output logic external_clock_input_mode,
  output logic medium_speed_crystal_mode,
  output logic high_speed_crystal_mode,
  output logic [8:0] aux_output_postdivider
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Code 000 takes the default branch, divide by 256; no code gives 128, the gap in the series
  function automatic logic [8:0] pfa_post_ratio(input logic [2:0] code);
    case (code)
      3'h7: pfa_post_ratio = 9'h001;
      3'h6: pfa_post_ratio = 9'h002;
      3'h5: pfa_post_ratio = 9'h004;
      3'h4: pfa_post_ratio = 9'h008;
      3'h3: pfa_post_ratio = 9'h010;
      3'h2: pfa_post_ratio = 9'h020;
      3'h1: pfa_post_ratio = 9'h040;
      default: pfa_post_ratio = 9'h100;
    endcase
  endfunction

  function automatic logic [15:0] pfa_merge(input logic [15:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [3:0] strb,
                                            input logic [15:0] mask);
    logic [15:0] merged;
    merged = old_val;
    if (strb[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = wdata[15:8];
    end
    pfa_merge = merged & mask;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] pll_mult_div;
  logic [15:0] aux_clk_ctrl;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic [11:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire logic [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire logic wr_fire = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
  wire logic wr_fbd = wr_fire && (wr_addr == PFA_OFS_PLL_MULT_DIV);
  wire logic wr_acc = wr_fire && (wr_addr == PFA_OFS_AUX_CLK_CTRL);
  wire logic wr_ok = wr_fbd || wr_acc;

  wire pfa_osc_mode_t osc_mode = pfa_osc_mode_t'(aux_clk_ctrl[PFA_MODE_MSB:PFA_MODE_LSB]);
  wire logic [15:0] fbd_rd = pll_mult_div & PFA_FBD_MASK;
  wire logic [15:0] acc_rd = aux_clk_ctrl & PFA_ACC_MASK;
  wire logic [9:0] next_mult = {1'b0, pll_mult_div[PFA_FBD_MSB:0]} + PFA_MULT_OFFSET;

  pfa_aux_cfg_t next_cfg;
  always_comb begin
    next_cfg.divider_from_aux = aux_clk_ctrl[PFA_SRC_SEL_BIT];
    next_cfg.ref_is_primary = aux_clk_ctrl[PFA_REF_SEL_BIT];
    next_cfg.osc_enables = 4'h0;
    next_cfg.osc_enables[osc_mode] = 1'b1;
    next_cfg.postdiv_ratio = pfa_post_ratio(aux_clk_ctrl[PFA_POST_MSB:PFA_POST_LSB]);
  end

  // Only power-on clears the configuration; the bus reset leaves it alone
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      pll_mult_div <= {7'h00, PFA_FBD_RESET};
      aux_clk_ctrl <= PFA_ACC_RESET;
    end else begin
      if (wr_fbd) begin
        pll_mult_div <= pfa_merge(pll_mult_div, wr_data, wr_strb, PFA_FBD_MASK);
      end
      if (wr_acc) begin
        aux_clk_ctrl <= pfa_merge(aux_clk_ctrl, wr_data, wr_strb, PFA_ACC_MASK);
      end
    end
  end

  // ----------------------------------------
  // Outputs to the clock generator
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      pll_multiplier <= {1'b0, PFA_FBD_RESET} + PFA_MULT_OFFSET;
      aux_divider_source_select <= 1'b0;
      aux_reference_source_select <= 1'b0;
      external_clock_input_mode <= 1'b0;
      medium_speed_crystal_mode <= 1'b0;
      high_speed_crystal_mode <= 1'b0;
      aux_output_postdivider <= pfa_post_ratio(PFA_ACC_RESET[PFA_POST_MSB:PFA_POST_LSB]);
    end else begin
      pll_multiplier <= next_mult;
      aux_divider_source_select <= next_cfg.divider_from_aux;
      aux_reference_source_select <= next_cfg.ref_is_primary;
      external_clock_input_mode <= next_cfg.osc_enables[PFA_OSC_EXTERNAL_CLOCK];
      medium_speed_crystal_mode <= next_cfg.osc_enables[PFA_OSC_MEDIUM_SPEED_CRYSTAL];
      high_speed_crystal_mode <= next_cfg.osc_enables[PFA_OSC_HIGH_SPEED_CRYSTAL];
      aux_output_postdivider <= next_cfg.postdiv_ratio;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PFA_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? PFA_RESP_OKAY : PFA_RESP_SLVERR;
      end else begin
        aw_held <= aw_held || aw_take;
        w_held <= w_held || w_take;
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      s_axi_awready <= !s_axi_awready && !aw_held && !aw_take && !s_axi_bvalid && !wr_fire;
      s_axi_wready <= !s_axi_wready && !w_held && !w_take && !s_axi_bvalid && !wr_fire;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [15:0] status_rd = {7'h00, next_cfg.postdiv_ratio};
  logic [15:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = 16'h0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == PFA_OFS_PLL_MULT_DIV) begin
      rd_word = fbd_rd;
    end else if (s_axi_araddr == PFA_OFS_AUX_CLK_CTRL) begin
      rd_word = acc_rd;
    end else if (s_axi_araddr == PFA_OFS_AUX_STATUS) begin
      rd_word = status_rd;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= PFA_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= rd_ok ? PFA_RESP_OKAY : PFA_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !ar_take;
    end
  end

endmodule

/* File: tb/pfa_clock_cfg_asserts.sv */
// Assertion checker for the PLL feedback and auxiliary clock configuration block
module pfa_clock_cfg_asserts
  import pfa_pkg::*;
(
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // Write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  // Read data
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Clock generator controls
  input wire logic [9:0] pll_multiplier,
  input wire logic aux_divider_source_select,
  input wire logic external_clock_input_mode,
  input wire logic medium_speed_crystal_mode,
  input wire logic high_speed_crystal_mode,
  input wire logic [8:0] aux_output_postdivider
);
  logic wr_go;
  logic [9:0] exp_mult;
  logic exp_src;
  // Only writes with both low bytes strobed give a fully known expectation
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_wstrb[1:0] == 2'h3;
  always_ff @(posedge aclk) begin
    if (wr_go) begin
      exp_mult <= s_axi_wdata[8:0] + 10'h002;
      exp_src <= s_axi_wdata[13];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_val_a: assert property ($rose(por_n) |->
    pll_multiplier == 10'h032 && aux_output_postdivider == 9'h100) else $error("Bad defaults");
  keep_cfg_a: assert property (@(posedge aclk) disable iff (!por_n) !aresetn |=>
    $stable(pll_multiplier) && $stable(aux_divider_source_select)) else $error("Config lost");
  mult_range_a: assert property (pll_multiplier >= 10'h002 && pll_multiplier <= 10'h201)
    else $error("Multiplier out of range");
  mult_wr_a: assert property (wr_go && s_axi_awaddr == PFA_OFS_PLL_MULT_DIV |->
    ##[1:3] pll_multiplier == exp_mult) else $error("Multiplier not updated");
  src_wr_a: assert property (wr_go && s_axi_awaddr == PFA_OFS_AUX_CLK_CTRL |->
    ##[1:3] aux_divider_source_select == exp_src) else $error("Source not updated");
  mode_hot_a: assert property ($onehot0({external_clock_input_mode,
    medium_speed_crystal_mode, high_speed_crystal_mode})) else $error("Modes overlap");
  post_hot_a: assert property ($onehot(aux_output_postdivider))
    else $error("Ratio not a power of two");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("Upper read bits set");
  cover property (wr_go);
  cover property ($rose(por_n));
  cover property (!aresetn && por_n);
endmodule
bind pfa_clock_cfg pfa_clock_cfg_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .pll_multiplier(pll_multiplier), .aux_divider_source_select(aux_divider_source_select),
  .external_clock_input_mode(external_clock_input_mode),
  .medium_speed_crystal_mode(medium_speed_crystal_mode),
  .high_speed_crystal_mode(high_speed_crystal_mode),
  .aux_output_postdivider(aux_output_postdivider));

/* File: tb/test_pfa_clock_cfg.sv */
// Self-checking testbench for the PLL feedback and auxiliary clock configuration block
module test_pfa_clock_cfg
  import pfa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, por_n, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [11:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, got;
  logic [3:0] w_s;
  logic [1:0] b_rs, r_rs, rs;
  logic [9:0] mult;
  logic src, refp, ext, med, hsp;
  logic [8:0] post;
  int mismatches, check_count;
  pfa_clock_cfg DUT (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_rs), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .pll_multiplier(mult), .aux_divider_source_select(src), .aux_reference_source_select(refp),
    .external_clock_input_mode(ext), .medium_speed_crystal_mode(med),
    .high_speed_crystal_mode(hsp), .aux_output_postdivider(post));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------
  // Bus and report helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    // Address and data are released on their own handshakes, in either order
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
      if (b_v) break;
    end
    b_r <= 1'b0;
    // A lost response ends the run at once rather than stalling later scenarios
    if (n == 50) begin
      mismatches++;
      $display("[ERR] %0t write response timed out", $time);
      end_sim();
    end
    chk(b_rs, e);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (ar_v && ar_r) ar_v <= 1'b0;
      if (r_v) break;
    end
    got = r_d;
    rs = r_rs;
    r_r <= 1'b0;
    if (n == 50) begin
      mismatches++;
      $display("[ERR] %0t read response timed out", $time);
      end_sim();
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(got, e);
    chk(rs, PFA_RESP_OKAY);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    rc(PFA_OFS_PLL_MULT_DIV, 32'h30);
    rc(PFA_OFS_AUX_CLK_CTRL, 32'h0);
    chk(mult, 32'h32);
    chk(post, 32'h100);
    chk({src, refp, ext, med, hsp}, 32'h0);
  endtask
  task automatic t_mult();
    logic [8:0] tbl [3] = '{9'h000, 9'h001, 9'h1FF};
    for (int i = 0; i < 3; i++) begin
      wr(PFA_OFS_PLL_MULT_DIV, {23'h7FFFFF, tbl[i]}, PFA_RESP_OKAY);
      rc(PFA_OFS_PLL_MULT_DIV, {23'h0, tbl[i]});
      chk(mult, tbl[i] + 10'h002);
    end
  endtask
  task automatic t_aux();
    logic [8:0] rat [8] = '{9'h100, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001};
    logic [15:0] v;
    // Unimplemented bits are written as ones so that masking is seen
    for (int i = 0; i < 8; i++) begin
      v = {2'h3, i[0], i[1:0], i[2:0], ~i[1], 7'h7F};
      wr(PFA_OFS_AUX_CLK_CTRL, {16'hFFFF, v}, PFA_RESP_OKAY);
      rc(PFA_OFS_AUX_CLK_CTRL, {16'h0, v & 16'h3F80});
      chk({src, refp}, {i[0], ~i[1]});
      chk({ext, med, hsp}, {i[1:0] == 2'h3, i[1:0] == 2'h2, i[1:0] == 2'h1});
      chk(post, rat[i]);
      rc(PFA_OFS_AUX_STATUS, rat[i]);
    end
  endtask
  task automatic t_strobe();
    // Low byte only: bit 8 of the field is kept from the previous write of all ones
    @(posedge aclk);
    w_s <= 4'h1;
    wr(PFA_OFS_PLL_MULT_DIV, 32'h00000000, PFA_RESP_OKAY);
    rc(PFA_OFS_PLL_MULT_DIV, 32'h100);
    chk(mult, 32'h102);
    w_s <= 4'hF;
  endtask
  task automatic t_refuse();
    wr(PFA_OFS_AUX_STATUS, 32'h0, PFA_RESP_SLVERR);
    rd(12'h0FC);
    chk(rs, PFA_RESP_SLVERR);
  endtask
  task automatic t_keep();
    wr(PFA_OFS_PLL_MULT_DIV, 32'h155, PFA_RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(PFA_OFS_PLL_MULT_DIV, 32'h155);
    chk(mult, 32'h157);
    @(posedge aclk);
    por_n <= 1'b0;
    repeat (2) @(posedge aclk);
    por_n <= 1'b1;
    t_defaults();
  endtask
  initial begin
    {aresetn, por_n, aw_v, w_v, b_r, ar_v, r_r} = 7'h00;
    aw_a = 12'h000;
    ar_a = 12'h000;
    w_d = 32'h0;
    w_s = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge aclk);
    t_defaults();
    t_mult();
    t_strobe();
    t_aux();
    t_refuse();
    t_keep();
    end_sim();
  end
endmodule
